// File: src/irq_stack_pkg.sv
/*
  Shared constants for the interrupt vector and mask-level stack block:
  register byte addresses, field layout, reset values and sizes.
  Assumes a 32-bit AHB-Lite address space with word registers.
*/
package irq_stack_pkg;

  // register byte addresses
  localparam logic [31:0] VECTOR_REG_ADDR = 32'hFFFFE040;
  localparam logic [31:0] MASK_LEVEL_REG_ADDR = 32'hFFFFE10C;

  // reset values
  localparam logic [31:0] VECTOR_REG_RESET = 32'h00000000;
  localparam logic [2:0] LEVEL_RESET = 3'h0;

  // sizes
  localparam int NUM_FACTORS = 64;
  localparam int FACTOR_W = 6;
  localparam int LVL_W = 3;
  localparam int STACK_DEPTH = 7;
  localparam int VEC_W = 9;

  // vector encoding: vector = (factor + base) * 4, low two bits zero
  localparam logic [6:0] VEC_BASE = 7'h01;

  // mask-level register layout
  localparam int CURRENT_MASK_FIELD_LSB = 0;
  localparam int SLOT_LSB = 4;
  localparam int SLOT_PITCH = 4;
  localparam int LEVEL_CHANGE_BIT = 31;

  // ahb encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// File: src/irq_stack_if.sv
/*
  Carriers between the top module and its two helpers: the mask stack
  operations and the factor arbitration result.
  Assumes all parties run on the one block clock.
*/
interface mask_stack_if;
  import irq_stack_pkg::*;
  logic push;
  logic pop;
  logic load;
  logic [LVL_W-1:0] level_in;
  logic [LVL_W-1:0] current_mask_field;
  logic [STACK_DEPTH-1:0][LVL_W-1:0] slots;
  modport ctl (output push, pop, load, level_in, input current_mask_field, slots);
  modport stk (input push, pop, load, level_in, output current_mask_field, slots);
endinterface

interface factor_arb_if;
  import irq_stack_pkg::*;
  logic [NUM_FACTORS-1:0] req;
  logic [NUM_FACTORS-1:0][LVL_W-1:0] levels;
  logic valid;
  logic [FACTOR_W-1:0] winner;
  logic [LVL_W-1:0] win_level;
  modport ctl (output req, levels, input valid, winner, win_level);
  modport arb (input req, levels, output valid, winner, win_level);
endinterface

// File: src/factor_arbiter.sv
/*
  Combinational pick of the pending factor with the highest level;
  on a tie the lowest factor number wins. Level 0 never requests.
  Assumes request and level inputs are stable within a cycle.
*/
module factor_arbiter
  import irq_stack_pkg::*;
(
  // arbitration carrier
  factor_arb_if.arb a
);

  // scan downward so equal levels leave the lowest number standing
  always_comb begin
    a.valid = 1'b0;
    a.winner = '0;
    a.win_level = '0;
    for (int i = NUM_FACTORS - 1; i >= 0; i--) begin
      // [RL10] [RL11] higher level wins, tie to lower number
      if (a.req[i] && a.levels[i] != '0 && a.levels[i] >= a.win_level) begin
        a.valid = 1'b1;
        a.winner = FACTOR_W'(i);
        a.win_level = a.levels[i];
      end
    end
  end

endmodule

// File: src/mask_stack.sv
/*
  Current mask level plus seven saved levels, with push, pop and
  overwrite. Assumes at most one of push, pop and load per cycle.
*/
module mask_stack
  import irq_stack_pkg::*;
(
  // clock and control
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // stack carrier
  mask_stack_if.stk s
);

  logic [LVL_W-1:0] current_mask_field_ff;
  logic [STACK_DEPTH-1:0][LVL_W-1:0] slot_ff;

  assign s.current_mask_field = current_mask_field_ff;
  assign s.slots = slot_ff;

  // current level: push or load takes new value, pop takes slot 0
  always_ff @(posedge clock) begin
    if (rst) begin
      current_mask_field_ff <= LEVEL_RESET;
    end else if (ce) begin
      if (s.push || s.load) begin
        current_mask_field_ff <= s.level_in;
      end else if (s.pop) begin
        current_mask_field_ff <= slot_ff[0];
      end
    end
  end

  // saved slots shift deeper on push, up on pop
  always_ff @(posedge clock) begin
    if (rst) begin
      slot_ff <= '0;
    end else if (ce) begin
      if (s.push) begin
        slot_ff[0] <= current_mask_field_ff;
        for (int i = 1; i < STACK_DEPTH; i++) begin
          slot_ff[i] <= slot_ff[i-1];
        end
      end else if (s.pop) begin
        for (int i = 0; i < STACK_DEPTH - 1; i++) begin
          slot_ff[i] <= slot_ff[i+1];
        end
        // [RL6] deepest slot zeroed
        slot_ff[STACK_DEPTH-1] <= LEVEL_RESET;
      end
    end
  end

  a_push_shift: assert property (@(posedge clock) disable iff (rst) // [RL3]
    (ce && s.push) |=> slot_ff[0] == $past(current_mask_field_ff) &&
      slot_ff[6] == $past(slot_ff[5]))
    else $error("push did not shift saved levels");

  a_pop_zero: assert property (@(posedge clock) disable iff (rst) // [RL6]
    (ce && s.pop && !s.push) |=> slot_ff[6] == 3'h0 &&
      current_mask_field_ff == $past(slot_ff[0]))
    else $error("pop did not restore and zero deepest slot");

  a_load_keeps: assert property (@(posedge clock) disable iff (rst) // [RL4]
    (ce && s.load && !s.push) |=> $stable(slot_ff))
    else $error("level overwrite disturbed saved slots");

endmodule

// File: src/irq_vector_and_mask_stack.sv
/*
  Interrupt vector register and nested mask-level stack with an
  AHB-Lite register slave. Pending factors and their levels arrive from
  the detection logic; the block arbitrates them, raises the level to
  the core and keeps the mask history.
  Assumes one clock, synchronous inputs, and ce high through the data
  phase of any write.
*/
// Design decision made here: the AHB-Lite register port.
// Contract
// [RL1] The vector register shows the current factor's vector in bits 8:0.
// [RL2] Software uses only full 32-bit accesses to the mask-level register.
// [RL3] A new interrupt loads its level as current and pushes older levels.
// [RL4] Writing 1 to the change bit overwrites the current level only.
// [RL5] Writing 0 to the change bit pops the saved levels up by one.
// [RL6] A pop fills the deepest saved slot with zero.
// [RL7] Software pops the stack before the exception-return instruction.
// [RL8] Current level, seven saved slots and the change bit sit as mapped.
// [RL9] With nothing pending or after a request clear the vector is zero; an acceptance in the clear's cycle loads the new vector instead.
// [RL10] Equal-level factors resolve to the lowest request number.
// [RL11] The highest level is reported and lower ones stay pending.
// [RL12] Gap bits and the write-only change bit read as zero.
module irq_vector_and_mask_stack
  import irq_stack_pkg::*;
(
  // clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // factor side
  input wire logic [NUM_FACTORS-1:0] factor_req,
  input wire logic [NUM_FACTORS*LVL_W-1:0] factor_levels,
  input wire logic request_clear,
  // core side
  output logic int_req,
  output logic [LVL_W-1:0] int_level
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  mask_stack_if stk_c ();
  factor_arb_if arb_c ();

  mask_stack u_stack (
    .clock (clock),
    .rst (rst),
    .ce (ce),
    .s (stk_c.stk)
  );

  factor_arbiter u_arb (
    .a (arb_c.arb)
  );

  assign arb_c.req = factor_req;
  assign arb_c.levels = factor_levels;

  ////////////////////////////////////////////////////////////////////////
  // bus state

  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic rd_pend_ff;
  logic wr_pend_ff;
  logic [31:0] addr_ff;
  logic [VEC_W-1:0] vector_ff;
  logic int_req_ff;
  logic [LVL_W-1:0] int_level_ff;

  logic addr_take;
  logic mask_wr;
  logic accept;
  logic [31:0] rd_mux;
  logic [6:0] vec_hi;

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign int_req = int_req_ff;
  assign int_level = int_level_ff;

  // address phase accepted only when the bus is ready
  assign addr_take = hsel && htrans == HTRANS_NONSEQ && hready;

  // write data phase to the mask-level register, full words only
  // [RL2] whole-word write expected
  assign mask_wr = wr_pend_ff && hready && addr_ff == MASK_LEVEL_REG_ADDR;

  // capture address phase; reads get one wait state so they see
  // a write that completes in the same cycle as their address phase
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_pend_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      addr_ff <= '0;
    end else if (ce) begin
      if (addr_take) begin
        rd_pend_ff <= !hwrite;
        wr_pend_ff <= hwrite && hsize == HSIZE_WORD;
        addr_ff <= haddr;
      end else begin
        rd_pend_ff <= 1'b0;
        if (hready) begin
          wr_pend_ff <= 1'b0;
        end
      end
    end
  end

  // ready drops for one cycle on a read, always OKAY response
  always_ff @(posedge clock) begin
    if (rst) begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else if (ce) begin
      hreadyout_ff <= !(addr_take && !hwrite);
      hresp_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data

  // assemble register images; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    if (addr_ff == VECTOR_REG_ADDR) begin
      // [RL1] vector in low nine bits
      rd_mux[VEC_W-1:0] = vector_ff;
    end else if (addr_ff == MASK_LEVEL_REG_ADDR) begin
      // [RL8] field placement
      rd_mux[CURRENT_MASK_FIELD_LSB +: LVL_W] = stk_c.current_mask_field;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        rd_mux[SLOT_LSB + SLOT_PITCH*i +: LVL_W] = stk_c.slots[i];
      end
      // [RL12] gap bits and change bit stay zero
      rd_mux[LEVEL_CHANGE_BIT] = 1'b0;
    end
  end

  // data latched in the wait cycle, held until the next read
  always_ff @(posedge clock) begin
    if (rst) begin
      hrdata_ff <= '0;
    end else if (ce && rd_pend_ff) begin
      hrdata_ff <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt acceptance and stack control

  // a new interrupt needs a level above the current mask; a software
  // write in the same cycle goes first and the interrupt retries next
  // [RL11] highest level only
  assign accept = arb_c.valid && arb_c.win_level > stk_c.current_mask_field && !mask_wr;

  // [RL3] push on acceptance
  assign stk_c.push = accept;
  // [RL4] overwrite with written level
  assign stk_c.load = mask_wr && hwdata[LEVEL_CHANGE_BIT];
  // [RL5] pop on zero change bit
  assign stk_c.pop = mask_wr && !hwdata[LEVEL_CHANGE_BIT];
  assign stk_c.level_in = accept ? arb_c.win_level
                                 : hwdata[CURRENT_MASK_FIELD_LSB +: LVL_W];

  // [RL10] winning factor's vector latched
  assign vec_hi = 7'(arb_c.winner) + VEC_BASE;

  // vector register: acceptance beats a simultaneous clear
  always_ff @(posedge clock) begin
    if (rst) begin
      vector_ff <= VECTOR_REG_RESET[VEC_W-1:0];
    end else if (ce) begin
      if (accept) begin
        vector_ff <= {vec_hi, 2'b00};
      // [RL9] clear or nothing pending
      end else if (request_clear || !arb_c.valid) begin
        vector_ff <= '0;
      end
    end
  end

  // level notification to the core follows the arbiter each cycle that ce is high
  always_ff @(posedge clock) begin
    if (rst) begin
      int_req_ff <= 1'b0;
      int_level_ff <= LEVEL_RESET;
    end else if (ce) begin
      int_req_ff <= arb_c.valid;
      int_level_ff <= arb_c.win_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  // a requesting lower-numbered factor at the winning level means a lost
  // tie; kept apart from the arbiter so the check does not reuse its
  // scan order
  logic tie_lower;
  always_comb begin
    tie_lower = 1'b0;
    for (int i = 0; i < NUM_FACTORS; i++) begin
      if (factor_req[i] &&
          factor_levels[LVL_W*i +: LVL_W] == arb_c.win_level &&
          FACTOR_W'(i) < arb_c.winner) begin
        tie_lower = 1'b1;
      end
    end
  end

  a_push_level: assert property (@(posedge clock) disable iff (rst) // [RL3]
    (ce && accept) |=> stk_c.current_mask_field == $past(arb_c.win_level))
    else $error("accepted level not loaded as current");

  a_load_level: assert property (@(posedge clock) disable iff (rst) // [RL4]
    (ce && mask_wr && hwdata[31]) |=> stk_c.current_mask_field == $past(hwdata[2:0]))
    else $error("written level not loaded");

  a_pop_restore: assert property (@(posedge clock) disable iff (rst) // [RL5]
    (ce && mask_wr && !hwdata[31]) |=>
      stk_c.current_mask_field == $past(stk_c.slots[0]) &&
      stk_c.slots[0] == $past(stk_c.slots[1]))
    else $error("pop did not move levels up");

  a_vec_value: assert property (@(posedge clock) disable iff (rst) // [RL1]
    (ce && accept) |=>
      vector_ff == {7'($past(arb_c.winner)) + VEC_BASE, 2'b00})
    else $error("vector does not match winning factor");

  a_vec_clear: assert property (@(posedge clock) disable iff (rst) // [RL9]
    (ce && !accept && (request_clear || !arb_c.valid)) |=> vector_ff == 0)
    else $error("vector not cleared");

  a_rd_gaps: assert property (@(posedge clock) disable iff (rst) // [RL12]
    (ce && rd_pend_ff && addr_ff == MASK_LEVEL_REG_ADDR) |=>
      (hrdata_ff & 32'h88888888) == 32'h00000000)
    else $error("reserved mask-level bits read nonzero");

  a_rd_fields: assert property (@(posedge clock) disable iff (rst) // [RL8]
    (ce && rd_pend_ff && addr_ff == MASK_LEVEL_REG_ADDR) |=>
      hrdata_ff[2:0] == $past(stk_c.current_mask_field) &&
      hrdata_ff[30:28] == $past(stk_c.slots[6]))
    else $error("mask-level read image wrong");

  a_report_top: assert property (@(posedge clock) disable iff (rst) // [RL11]
    (ce && arb_c.valid) |=> int_req_ff && int_level == $past(arb_c.win_level))
    else $error("highest level not reported");

  a_tie_lowest: assert property (@(posedge clock) disable iff (rst) // [RL10]
    arb_c.valid |-> !tie_lower)
    else $error("tie not resolved to lowest number");

  a_rd_wait: assert property (@(posedge clock) disable iff (rst)
    (ce && addr_take && !hwrite) |=> !hreadyout ##1
      (!$past(ce) || hreadyout))
    else $error("read wait state wrong");

  a_write_no_wait: assert property (@(posedge clock) disable iff (rst)
    (ce && addr_take && hwrite) |=> hreadyout_ff)
    else $error("write data phase stalled");

  a_rd_hold: assert property (@(posedge clock) disable iff (rst)
    !(ce && rd_pend_ff) |=> $stable(hrdata_ff))
    else $error("read data moved outside a read");

  a_current_mask_field_hold: assert property (@(posedge clock) disable iff (rst) // [RL8]
    !(ce && (stk_c.push || stk_c.load || stk_c.pop)) |=>
      $stable(stk_c.current_mask_field))
    else $error("current level moved without a cause");

  a_no_low_push: assert property (@(posedge clock) disable iff (rst) // [RL11]
    (arb_c.win_level <= stk_c.current_mask_field) |-> !stk_c.push)
    else $error("level not above current mask was pushed");

  a_push_rises: assert property (@(posedge clock) disable iff (rst) // [RL11]
    (ce && stk_c.push) |=> stk_c.current_mask_field > $past(stk_c.current_mask_field))
    else $error("accepted level not above the old mask");

  a_int_idle: assert property (@(posedge clock) disable iff (rst) // [RL9]
    (ce && !arb_c.valid) |=> !int_req_ff && int_level_ff == 3'h0)
    else $error("request shown with nothing pending");

  a_freeze_all: assert property (@(posedge clock) disable iff (rst)
    !ce |=> $stable(vector_ff) && $stable(int_req_ff) &&
      $stable(int_level_ff) && $stable(stk_c.current_mask_field))
    else $error("state moved while clock enable low");

endmodule

// File: tb/core_model.sv
/*
  Behavioural processor core: an AHB-Lite master that issues single
  word transfers and hands read data to the bench through an event.
  Assumes hready is the slave's hreadyout and one shared clock.
*/
module core_model (
  // clock
  input wire logic clock,
  // ahb-lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rd_data;
  event got;
  ////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    hsize <= 3'h2;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    // released data line shows garbage, never the stale word; select
    // stays up so a next call in this step drives it only once
    hwdata <= ~d;
    if (!w) begin
      rd_data = hrdata;
      -> got;
    end
  endtask
endmodule

// File: tb/irq_vector_and_mask_stack_bench.sv
/*
  Self-checking bench: the core model reads the two registers and writes
  the mask-level one while the bench drives factor requests and keeps its own
  copy of the mask stack. Assumes the design package is compiled first.
*/
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin \
  mismatches++; $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module irq_vector_and_mask_stack_bench;
  import irq_stack_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, ce, hsel, hwrite, hreadyout, hresp, request_clear;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [NUM_FACTORS-1:0] factor_req;
  logic [NUM_FACTORS*LVL_W-1:0] factor_levels;
  logic int_req;
  logic [LVL_W-1:0] int_level;
  logic [31:0] exp_q[$];
  string nm_q[$];
  logic [2:0] stk[8];
  logic [31:0] seed = 32'hAA17;
  int mismatches = 0, n_tests = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////
  irq_vector_and_mask_stack irq_vector_and_mask_stack_inst (
    .clock(clock), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .factor_req(factor_req),
    .factor_levels(factor_levels), .request_clear(request_clear),
    .int_req(int_req), .int_level(int_level));
  core_model core_model_inst (
    .clock(clock), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));
  ////////////////////////////////////////////////////////////////////
  // clock and hang guard; the run needs well under 2000 cycles
  initial clock = 1'b0;
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc > 5000) begin
      mismatches++;
      close_out();
    end
  end
  // watcher: oldest note against each read that completes
  initial forever begin
    logic [31:0] e;
    string nm;
    @(core_model_inst.got);
    e = exp_q.pop_front();
    nm = nm_q.pop_front();
    `CHK(nm, e, core_model_inst.rd_data)
  end
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // packed register image of the bench's stack copy, gaps zero
  function automatic logic [31:0] mword();
    logic [31:0] m = 32'h0;
    for (int k = 0; k < 8; k++) m[4*k +: 3] = stk[k];
    return m;
  endfunction
  function automatic void push(input logic [2:0] l);
    for (int k = 7; k > 0; k--) stk[k] = stk[k-1];
    stk[0] = l;
  endfunction
  function automatic void pop();
    for (int k = 0; k < 7; k++) stk[k] = stk[k+1];
    stk[7] = 3'h0;
  endfunction
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e,
                        input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    core_model_inst.xfer(1'b0, a, 32'h0);
  endtask
  task automatic raise(input int n, input logic [2:0] l);
    factor_levels[n*3 +: 3] <= l;
    factor_req[n] <= 1'b1;
  endtask
  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int n;
    logic [2:0] l;
    rst = 1'b1;
    ce = 1'b1;
    factor_req = '0;
    factor_levels = '0;
    request_clear = 1'b0;
    for (int k = 0; k < 8; k++) stk[k] = 3'h0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd_chk(MASK_LEVEL_REG_ADDR, 32'h0, "mask reset");
    rd_chk(VECTOR_REG_ADDR, VECTOR_REG_RESET, "vector reset");
    rd_chk(32'hFFFFE044, 32'h0, "unmapped read");
    $display("test reset done");
    raise(5, 3'h4);
    repeat (3) @(posedge clock);
    push(3'h4);
    `CHK("int_req", 1'b1, int_req)
    `CHK("int_level", 3'h4, int_level)
    rd_chk(VECTOR_REG_ADDR, 32'h18, "vector f5");
    rd_chk(MASK_LEVEL_REG_ADDR, mword(), "push one");
    raise(9, 3'h6);
    raise(3, 3'h6);
    raise(1, 3'h5);
    repeat (3) @(posedge clock);
    push(3'h6);
    `CHK("int_level", 3'h6, int_level)
    rd_chk(VECTOR_REG_ADDR, 32'h10, "vector tie");
    rd_chk(MASK_LEVEL_REG_ADDR, mword(), "push two");
    request_clear <= 1'b1;
    @(posedge clock);
    request_clear <= 1'b0;
    @(posedge clock);
    rd_chk(VECTOR_REG_ADDR, 32'h0, "vector clear");
    factor_req <= '0;
    core_model_inst.xfer(1'b1, MASK_LEVEL_REG_ADDR, 32'hF7777772);
    stk[0] = 3'h2;
    rd_chk(MASK_LEVEL_REG_ADDR, mword(), "overwrite");
    $display("test push and overwrite done");
    // nine pushes overflow the seven saved slots
    for (int i = 0; i < 9; i++) begin
      core_model_inst.xfer(1'b1, MASK_LEVEL_REG_ADDR, 32'h80000000);
      stk[0] = 3'h0;
      n = int'(xs() % 64);
      l = 3'(1 + xs() % 7);
      raise(n, l);
      repeat (3) @(posedge clock);
      factor_req[n] <= 1'b0;
      push(l);
    end
    rd_chk(MASK_LEVEL_REG_ADDR, mword(), "deep push");
    for (int i = 0; i < 8; i++) begin
      core_model_inst.xfer(1'b1, MASK_LEVEL_REG_ADDR, 32'h0);
      pop();
      rd_chk(MASK_LEVEL_REG_ADDR, mword(), "pop");
    end
    `CHK("hresp", 1'b0, hresp)
    `CHK("hreadyout", 1'b1, hreadyout)
    $display("test stack depth done");
    // clock enable low must hold off acceptance and the level outputs
    ce <= 1'b0;
    raise(2, 3'h3);
    repeat (3) @(posedge clock);
    `CHK("int_req", 1'b0, int_req)
    ce <= 1'b1;
    repeat (3) @(posedge clock);
    push(3'h3);
    `CHK("int_level", 3'h3, int_level)
    rd_chk(VECTOR_REG_ADDR, 32'h0C, "vector f2");
    rd_chk(MASK_LEVEL_REG_ADDR, mword(), "frozen push");
    factor_req <= '0;
    repeat (2) @(posedge clock);
    rd_chk(VECTOR_REG_ADDR, 32'h0, "vector idle");
    $display("test clock enable done");
    repeat (2) @(posedge clock);
    close_out();
  end
endmodule
